// ===== design/input_cond_pkg.sv
package input_cond_pkg;

  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] OFS_CTRL_LINE1   = 8'h00;
  localparam logic [7:0] OFS_CTRL_GENERIC = 8'h04;
  localparam logic [7:0] OFS_FRAC_DIV     = 8'h08;

  // Control register field positions
  localparam int SRC_LSB    = 0;
  localparam int DELAY_COMP_ENABLE_BIT   = 3;
  localparam int INPUT_PATH_SWITCH_BIT   = 4;
  localparam int FILTER_ENABLE_BIT   = 5;
  localparam int SYNC_ENABLE_BIT   = 6;
  localparam int INPUT_POLARITY_INVERT_BIT   = 8;
  localparam int FILTER_SAMPLE_RATE_SELECT_BIT  = 9;
  localparam int MODE_LSB   = 10;
  localparam int STATUS_BIT = 15;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Writable bits; bit 3 only exists on line-1 stage
  localparam logic [31:0] CTRL_WMASK_LINE1   = 32'h0000_0F7F;
  localparam logic [31:0] CTRL_WMASK_GENERIC = 32'h0000_0F77;
  localparam logic [9:0]  STEP_RESET         = 10'h000;

  // Source codes: 110 and 111 both pick line G
  localparam logic [2:0] SRC_LINE_G = 3'h6;

  // Filter: input must be stable this many samples to be taken
  localparam int FILTER_SAMPLES = 3;

  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;

  typedef struct packed {
    logic [2:0] src_sel;
    logic       delay_comp_enable;
    logic       input_path_switch;
    logic       filter_enable;
    logic       sync_enable;
    logic       input_polarity_invert;
    logic       filter_sample_rate_select;
    edge_mode_t edge_trigger_mode;
  } stage_cfg_t;

  typedef struct packed {
    logic shift_data;
    logic shift_clock;
    logic trigger;
    logic level;
  } stage_out_t;

  function automatic stage_cfg_t cfg_from_word(input logic [31:0] w);
    stage_cfg_t c;
    c.src_sel                   = w[SRC_LSB +: 3];
    c.delay_comp_enable         = w[DELAY_COMP_ENABLE_BIT];
    c.input_path_switch         = w[INPUT_PATH_SWITCH_BIT];
    c.filter_enable             = w[FILTER_ENABLE_BIT];
    c.sync_enable               = w[SYNC_ENABLE_BIT];
    c.input_polarity_invert     = w[INPUT_POLARITY_INVERT_BIT];
    c.filter_sample_rate_select = w[FILTER_SAMPLE_RATE_SELECT_BIT];
    c.edge_trigger_mode         = edge_mode_t'(w[MODE_LSB +: 2]);
    return c;
  endfunction : cfg_from_word

endpackage : input_cond_pkg

// ===== design/frac_divider.sv
`timescale 1ns/100ps
// Fractional divider: accumulator adds step each clock; carry is the enable
module frac_divider
  import input_cond_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [9:0] step,
  output logic            divided_clock_rate
);
  logic [9:0]  acc_ff;
  wire  [10:0] sum = {1'b0, acc_ff} + {1'b0, step};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_ff             <= 10'h000;
      divided_clock_rate <= 1'b0;
    end
    else
    begin
      acc_ff             <= sum[9:0];
      divided_clock_rate <= sum[10];
    end
  end
endmodule : frac_divider

// ===== design/input_stage.sv
`timescale 1ns/100ps
module input_stage
  import input_cond_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  stage_cfg_t      cfg,
  input  wire logic [6:0] candidate_input_lines,
  input  wire logic       preproc_data,
  input  wire logic       sample_en_fd,
  output stage_out_t      outs
);
  // Line G answers codes 110 and 111
  wire [2:0] src       = (cfg.src_sel > SRC_LINE_G) ? SRC_LINE_G : cfg.src_sel;
  wire       selected  = candidate_input_lines[src];
  wire       polarized = selected ^ cfg.input_polarity_invert;

  logic       sync1_ff, sync2_ff, filt_ff, level_ff;
  logic [1:0] cnt_ff;
  wire        sample_en = cfg.filter_sample_rate_select ? sample_en_fd : 1'b1;
  wire        conditioned = cfg.filter_enable ? filt_ff : sync2_ff;
  wire        rise = conditioned & ~level_ff;
  wire        fall = ~conditioned & level_ff;
  wire        fire = (cfg.edge_trigger_mode == EDGE_RISE && rise) ||
                     (cfg.edge_trigger_mode == EDGE_FALL && fall) ||
                     (cfg.edge_trigger_mode == EDGE_BOTH && (rise || fall));
  wire        data_in = cfg.sync_enable ? conditioned : polarized;
  wire        shift_d = cfg.input_path_switch ? data_in : preproc_data;
  wire        shift_c = cfg.delay_comp_enable ? selected : shift_d;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      filt_ff  <= 1'b0;
      cnt_ff   <= 2'h0;
      level_ff <= 1'b0;
      outs     <= '0;
    end
    else
    begin
      sync1_ff <= polarized;
      sync2_ff <= sync1_ff;
      // Glitch filter: change only after a stable run of samples
      if (sample_en)
      begin
        if (sync2_ff == filt_ff)
          cnt_ff <= 2'h0;
        else if (cnt_ff == 2'(FILTER_SAMPLES - 1))
        begin
          filt_ff <= sync2_ff;
          cnt_ff  <= 2'h0;
        end
        else
          cnt_ff <= cnt_ff + 2'h1;
      end
      level_ff         <= conditioned;
      outs.level       <= conditioned;
      outs.trigger     <= fire;
      outs.shift_data  <= shift_d;
      outs.shift_clock <= shift_c;
    end
  end

  a_trig_one_cycle : assert property (@(posedge hclk) disable iff (!hresetn)
    outs.trigger |=> !outs.trigger || (cfg.edge_trigger_mode == EDGE_BOTH))
    else $error("trigger longer than expected");
  a_trig_off_quiet : assert property (@(posedge hclk) disable iff (!hresetn)
    $past(cfg.edge_trigger_mode) == EDGE_OFF |-> !outs.trigger)
    else $error("trigger while disabled");
  a_level_tracks : assert property (@(posedge hclk) disable iff (!hresetn)
    outs.level == $past(conditioned))
    else $error("level status stale");
endmodule : input_stage

// ===== design/serial_input_conditioning.sv
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module serial_input_conditioning
  import input_cond_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [6:0]  candidate_input_lines,
  input  wire logic [6:0]  generic_input_lines,
  input  wire logic        preproc_data_line1,
  input  wire logic        preproc_data_generic,
  output logic             conditioned_input_signal,
  output logic             input_trigger_pulse,
  output logic             shift_data_line1,
  output logic             shift_clock_line1,
  output logic             stage_trigger_pulse,
  output logic             stage_level,
  output logic             shift_data_generic
);
  logic [31:0] ctrl1_ff, ctrlg_ff;
  logic [9:0]  step_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  stage_out_t  out1, outg;
  logic        fd_en;

  // Address phase: writes must be single word, other write sizes are ignored; reads take any size
  wire       take   = hsel & hready & htrans[1];
  wire [7:0] a_ofs  = haddr[7:0];
  wire       is_rd  = take & ~hwrite;
  wire       is_wr  = take & hwrite & (hsize == 3'h2);

  // A read right behind a write sees the new word, which lands only at this edge
  wire        wr1_now  = wr_pend_ff & (wr_addr_ff == OFS_CTRL_LINE1);
  wire        wrg_now  = wr_pend_ff & (wr_addr_ff == OFS_CTRL_GENERIC);
  wire        wrs_now  = wr_pend_ff & (wr_addr_ff == OFS_FRAC_DIV);
  wire [31:0] ctrl1_rd = wr1_now ? hwdata : ctrl1_ff;
  wire [31:0] ctrlg_rd = wrg_now ? hwdata : ctrlg_ff;
  wire [9:0]  step_rd  = wrs_now ? hwdata[9:0] : step_ff;

  // Readback: reserved bits are zero by mask, status bit from the stage
  wire [31:0] rd_line1 = (ctrl1_rd & CTRL_WMASK_LINE1)
                         | (32'(out1.level) << STATUS_BIT);
  wire [31:0] rd_gen   = (ctrlg_rd & CTRL_WMASK_GENERIC)
                         | (32'(outg.level) << STATUS_BIT);
  wire [31:0] rd_mux   = (a_ofs == OFS_CTRL_LINE1)   ? rd_line1 :
                         (a_ofs == OFS_CTRL_GENERIC) ? rd_gen :
                         (a_ofs == OFS_FRAC_DIV)     ? {22'h0, step_rd} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
    else
    begin
      wr_pend_ff <= is_wr;
      wr_addr_ff <= a_ofs;
      if (is_rd)
        hrdata <= rd_mux;
    end
  end

  // Data-phase write; bit 3 of the generic stage never latches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl1_ff <= CTRL_RESET;
      ctrlg_ff <= CTRL_RESET;
      step_ff  <= STEP_RESET;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == OFS_CTRL_LINE1)
        ctrl1_ff <= hwdata & CTRL_WMASK_LINE1;
      if (wr_addr_ff == OFS_CTRL_GENERIC)
        ctrlg_ff <= hwdata & CTRL_WMASK_GENERIC;
      if (wr_addr_ff == OFS_FRAC_DIV)
        step_ff <= hwdata[9:0];
    end
  end

  frac_divider u_fd (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .step               (step_ff),
    .divided_clock_rate (fd_en)
  );

  input_stage u_line1 (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .cfg                   (cfg_from_word(ctrl1_ff)),
    .candidate_input_lines (candidate_input_lines),
    .preproc_data          (preproc_data_line1),
    .sample_en_fd          (fd_en),
    .outs                  (out1)
  );

  input_stage u_generic (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .cfg                   (cfg_from_word(ctrlg_ff)),
    .candidate_input_lines (generic_input_lines),
    .preproc_data          (preproc_data_generic),
    .sample_en_fd          (fd_en),
    .outs                  (outg)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      conditioned_input_signal <= 1'b0;
      input_trigger_pulse      <= 1'b0;
      shift_data_line1         <= 1'b0;
      shift_clock_line1        <= 1'b0;
      stage_trigger_pulse      <= 1'b0;
      stage_level              <= 1'b0;
      shift_data_generic       <= 1'b0;
    end
    else
    begin
      conditioned_input_signal <= out1.level;
      input_trigger_pulse      <= out1.trigger;
      shift_data_line1         <= out1.shift_data;
      shift_clock_line1        <= out1.shift_clock;
      stage_trigger_pulse      <= outg.trigger;
      stage_level              <= outg.level;
      shift_data_generic       <= outg.shift_data;
    end
  end

  // Raw selected line of the first stage, two register stages ahead of the pin
  wire sel1_raw = candidate_input_lines[(ctrl1_ff[2:0] > SRC_LINE_G) ?
                                        SRC_LINE_G : ctrl1_ff[2:0]];

  a_rsv_zero : assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl1_ff[31:16] == 16'h0) && !ctrl1_ff[7] && (ctrlg_ff[3] == 1'b0))
    else $error("reserved control bit set");
  a_gen_bit3 : assert property (@(posedge hclk) disable iff (!hresetn)
    is_rd && a_ofs == OFS_CTRL_GENERIC |=> hrdata[3] == 1'b0)
    else $error("generic bit 3 not zero");
  a_clk_direct : assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl1_ff[DELAY_COMP_ENABLE_BIT] |-> ##2 shift_clock_line1 == $past(sel1_raw, 2))
    else $error("shift clock not from selected line");
  a_bus_okay : assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not OKAY");
  a_wr_lands : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && wr_addr_ff == OFS_CTRL_LINE1 |=>
    ctrl1_ff == ($past(hwdata) & CTRL_WMASK_LINE1))
    else $error("control write lost");
  a_status_rd : assert property (@(posedge hclk) disable iff (!hresetn)
    is_rd && a_ofs == OFS_CTRL_LINE1 |=> hrdata[STATUS_BIT] == $past(out1.level))
    else $error("status bit not current level");
endmodule : serial_input_conditioning

// ===== testbench/line_model.sv
`timescale 1ns/100ps
// Pins and pre-processor output move only just after an edge, like real sync logic
module line_model
(
  input  wire logic       hclk,
  input  wire logic [6:0] want_lines,
  input  wire logic       want_pp,
  output logic [6:0]      lines,
  output logic            pp
);
  initial lines = 7'h00;
  initial pp = 1'b0;
  always @(posedge hclk)
  begin
    lines <= want_lines;
    pp    <= want_pp;
  end
endmodule : line_model

// ===== testbench/test_serial_input_conditioning.sv
`timescale 1ns/100ps
module test_serial_input_conditioning
  import input_cond_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pp, want_pp;
  logic        sd1, sc1, sdg, lvl1, lvlg, trg1, trgg;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [6:0]  lines, want;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  int          err_count, n_checks, n1, ng;

  serial_input_conditioning dut_u
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .candidate_input_lines(lines), .generic_input_lines(lines),
    .preproc_data_line1(pp), .preproc_data_generic(pp),
    .conditioned_input_signal(lvl1), .input_trigger_pulse(trg1),
    .shift_data_line1(sd1), .shift_clock_line1(sc1), .stage_trigger_pulse(trgg),
    .stage_level(lvlg), .shift_data_generic(sdg)
  );

  line_model pins_u
  (
    .hclk(hclk), .want_lines(want), .want_pp(want_pp), .lines(lines), .pp(pp)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [31:0] cfg(input logic [2:0] s, input logic p, d,
                                      input logic [1:0] m);
    return {20'h00000, m, 1'b0, p, 1'b0, d, 3'h0, s};
  endfunction : cfg

  // Codes 110 and 111 both land on line G
  function automatic logic [31:0] sel_exp(input logic [6:0] l, input logic [2:0] s,
                                          input logic p);
    logic [2:0] i;
    i = (s == 3'h7) ? 3'h6 : s;
    return 32'(l[i] ^ p);
  endfunction : sel_exp

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : xfer

  task automatic wr_both(input logic [31:0] d);
    xfer(OFS_CTRL_LINE1, 1'b1, d);
    xfer(OFS_CTRL_GENERIC, 1'b1, d);
  endtask : wr_both

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  always @(posedge hclk)
  begin
    if (trg1 === 1'b1) n1++;
    if (trgg === 1'b1) ng++;
  end

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // About 500 cycles are needed; forty times that means a hang
  initial
  begin
    #200000;
    err_count++;
    final_report();
  end

  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, want, want_pp} = '0;
    hsize = 3'h2;
    seed = 32'hBA6B;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(OFS_CTRL_LINE1, 1'b0, 32'h0);
    chk("ctrl1 reset", CTRL_RESET, rd);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      xfer(OFS_CTRL_LINE1, 1'b1, ~seed & CTRL_WMASK_LINE1);
      xfer(OFS_CTRL_GENERIC, 1'b1, ~seed & CTRL_WMASK_GENERIC);
      xfer(8'h0C, 1'b1, ~seed);
      xfer(8'h0C, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      xfer(OFS_CTRL_LINE1, 1'b0, 32'h0);
      chk("ctrl1", ~seed & CTRL_WMASK_LINE1, rd & 32'hFFFF7FFF);
      xfer(OFS_CTRL_GENERIC, 1'b0, 32'h0);
      chk("ctrlg", ~seed & CTRL_WMASK_GENERIC, rd & 32'hFFFF7FFF);
    end
    $display("test registers done");
    for (int c = 0; c < 16; c++)
    begin
      seed = lfsr(seed);
      want <= seed[6:0];
      wr_both(cfg(3'(c), c[3], c[0], 2'h0) | 32'h10);
      repeat (8) @(posedge hclk);
      chk("data1", sel_exp(seed[6:0], 3'(c), c[3]), 32'(sd1));
      chk("datag", sel_exp(seed[6:0], 3'(c), c[3]), 32'(sdg));
      chk("level1", sel_exp(seed[6:0], 3'(c), c[3]), 32'(lvl1));
      chk("levelg", sel_exp(seed[6:0], 3'(c), c[3]), 32'(lvlg));
    end
    $display("test selection done");
    for (int m = 0; m < 4; m++)
    begin
      want <= 7'h00;
      wr_both(cfg(3'h2, 1'b0, 1'b1, 2'(m)));
      repeat (10) @(posedge hclk);
      n1 = 0;
      ng = 0;
      want <= 7'h04;
      repeat (10) @(posedge hclk);
      want <= 7'h00;
      repeat (10) @(posedge hclk);
      chk("trig1", (m == 0) ? 0 : (m == 3) ? 2 : 1, 32'(n1));
      chk("trigg", (m == 0) ? 0 : (m == 3) ? 2 : 1, 32'(ng));
    end
    $display("test edges done");
    wr_both(cfg(3'h0, 1'b0, 1'b1, 2'h3) | 32'h20);
    repeat (10) @(posedge hclk);
    n1 = 0;
    want <= 7'h01;
    @(posedge hclk);
    want <= 7'h00;
    repeat (10) @(posedge hclk);
    chk("glitch trig", 32'h0, 32'(n1));
    wr_both(cfg(3'h0, 1'b0, 1'b1, 2'h3) | 32'h220);
    want <= 7'h01;
    repeat (30) @(posedge hclk);
    chk("stalled filter", 32'h0, 32'(lvl1));
    xfer(OFS_FRAC_DIV, 1'b1, 32'h200);
    repeat (20) @(posedge hclk);
    chk("divided filter", 32'h1, 32'(lvl1));
    xfer(OFS_CTRL_LINE1, 1'b0, 32'h0);
    chk("status bit", 32'h1, 32'(rd[15]));
    $display("test filter done");
    xfer(OFS_CTRL_LINE1, 1'b1, cfg(3'h3, 1'b0, 1'b0, 2'h0) | 32'h8);
    want <= 7'h08;
    want_pp <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("clk raw", 32'h1, 32'(sc1));
    chk("data pp", 32'h0, 32'(sd1));
    xfer(OFS_CTRL_LINE1, 1'b1, cfg(3'h3, 1'b0, 1'b0, 2'h0));
    want <= 7'h00;
    want_pp <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("clk pp", 32'h1, 32'(sc1));
    chk("data pp1", 32'h1, 32'(sd1));
    chk("datag pp", 32'h1, 32'(sdg));
    $display("test shift clock done");
    final_report();
  end
endmodule : test_serial_input_conditioning
